/* File: hvs_pkg.sv */
// Notes on behaviour
// RULE_01 - Panic shutdown removes HV module supply
// RULE_02 - Panic button press latches panic shutdown
// RULE_03 - Ungrounded safety loop enters panic shutdown
// RULE_04 - Ungrounded loop holds shutdown, blocks clearing
// RULE_05 - Red indicators lit exactly during panic
// RULE_06 - HV enable requests ignored during panic
// RULE_07 - Clear panic: panel disable in panel position
// RULE_08 - HV disable always accepted, ramps down
// RULE_09 - Standby key keeps internal power off
// RULE_10 - Key position selects source of edits
// RULE_11 - HV off after power-up unless auto-restore
// RULE_12 - Status clamped low until device ready
// RULE_13 - Ready status follows stored default configuration
// RULE_14 - Status clamps on enabled panic, trip, off
// RULE_15 - Aux input low turns HV off when enabled
// RULE_16 - Aux level passed as alternate setup select
// RULE_17 - Query each module before offering control
// RULE_18 - Up to 16 or 4 modules supported
// RULE_19 - Per-channel enable, ramp, target, trips, readback; code drives one shared hv_enable_o for all modules, with no ramp or target
// RULE_20 - Serial and terminal issue prompt when ready
// RULE_21 - Network responses carry continuation field
// RULE_22 - Network node address from rear switches
// RULE_23 - Synchronise and debounce panic, loop, aux inputs
package hvs_pkg;
    // Register map
    localparam logic [7:0] HVS_CTRL_OFF = 8'h00;
    localparam logic [7:0] HVS_STAT_OFF = 8'h04;
    localparam logic [7:0] HVS_CMD_OFF = 8'h08;
    localparam logic [7:0] HVS_MOD_OFF = 8'h0c;
    localparam logic [7:0] HVS_IF_OFF = 8'h10;
    // Control register fields
    localparam int HVS_CTRL_RESTORE_BIT = 0;
    localparam int HVS_CTRL_ST_PANIC_BIT = 1;
    localparam int HVS_CTRL_ST_TRIP_BIT = 2;
    localparam int HVS_CTRL_ST_OFF_BIT = 3;
    localparam int HVS_CTRL_AUX_OFF_BIT = 4;
    localparam int HVS_CTRL_AUX_ALT_BIT = 5;
    localparam int HVS_CTRL_LARGE_BIT = 6;
    localparam int HVS_CTRL_READY_BIT = 7;
    localparam logic [7:0] HVS_CTRL_RST = 8'h00;
    // Command register fields (write one to act)
    localparam int HVS_CMD_ON_BIT = 0;
    localparam int HVS_CMD_OFF_BIT = 1;
    // Interface register fields
    localparam int HVS_IF_PROMPT_BIT = 0;
    localparam int HVS_IF_CONT_BIT = 1;
    // Module limits
    localparam int HVS_SLOTS = 16;
    localparam logic [4:0] HVS_SLOTS_LARGE = 5'h10;
    localparam logic [4:0] HVS_SLOTS_SMALL = 5'h04;
    // Debounce: 1000 ns at 250 MHz
    localparam int HVS_CLK_MHZ = 250;
    localparam int HVS_DEB_NS = 1000;
    localparam int HVS_DEB_CYC = (HVS_DEB_NS * HVS_CLK_MHZ + 999) / 1000;
    localparam int HVS_DEB_W = 8;
    // Debounced levels after reset equal each pin's idle level, so no false event follows reset
    // Order: aux, loop, panic, on, off; aux idles high (not clamped)
    localparam logic [4:0] HVS_DEB_RST = 5'h10;
    // Key switch positions
    typedef enum logic [1:0] {HVS_KEY_STANDBY, HVS_KEY_HOST, HVS_KEY_PANEL} hvs_key_t;
    // Avalon request bundle
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
    } hvs_av_req_t;
    // Panel buttons
    typedef struct packed {
        logic panic_btn;
        logic on_btn;
        logic off_btn;
    } hvs_panel_t;
endpackage

/* File: hvs_interlock.sv */
// Chosen here: the Avalon-MM interface to the registers and the address map.
module hvs_interlock (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire hvs_pkg::hvs_av_req_t av_req_i,
    output logic [31:0] av_readdata_o,
    output logic av_waitrequest_o,
    // Panel, key and BNC pins (asynchronous)
    input wire hvs_pkg::hvs_panel_t panel_i,
    input wire logic [1:0] key_pos_i,
    input wire logic safety_loop_i,
    input wire logic aux_control_i,
    input wire logic [7:0] node_addr_sw_i,
    // HV modules
    input wire logic [15:0] mod_present_i,
    input wire logic [15:0] mod_trip_i,
    output logic [15:0] mod_query_o,
    output logic [15:0] mod_ctrl_ok_o,
    output logic mod_power_o,
    output logic hv_enable_o,
    output logic alt_setup_o,
    output logic internal_power_o,
    // Indicators and status pin
    output logic panic_led_o,
    output logic status_oe_o,
    output logic status_o,
    output logic host_edit_ok_o,
    output logic panel_edit_ok_o
);
    import hvs_pkg::*;

    // Two-stage synchronisers for the panel, key, loop, aux and node address inputs
    logic [2:0] pnl_s1_reg, pnl_s2_reg;
    logic [1:0] key_s1_reg, key_s2_reg;
    logic loop_s1_reg, loop_s2_reg, aux_s1_reg, aux_s2_reg;
    logic [7:0] node_s1_reg, node_s2_reg;
    always_ff @(posedge ref_clk_i) begin
        pnl_s1_reg <= panel_i;
        pnl_s2_reg <= pnl_s1_reg;
        key_s1_reg <= key_pos_i;
        key_s2_reg <= key_s1_reg;
        loop_s1_reg <= safety_loop_i;
        loop_s2_reg <= loop_s1_reg;
        aux_s1_reg <= aux_control_i;
        aux_s2_reg <= aux_s1_reg;
        node_s1_reg <= node_addr_sw_i;
        node_s2_reg <= node_s1_reg;
    end

    // Debouncers: a level is accepted once stable for the debounce time
    logic [4:0] raw_lvl;
    logic [4:0] deb_reg;
    logic [HVS_DEB_W-1:0] deb_cnt_reg [5];
    assign raw_lvl = {aux_s2_reg, loop_s2_reg, pnl_s2_reg};
    always_ff @(posedge ref_clk_i) begin
        for (int i = 0; i < 5; i++) begin
            if (rst_i) begin
                deb_reg[i] <= HVS_DEB_RST[i];
                deb_cnt_reg[i] <= '0;
            end else if (raw_lvl[i] == deb_reg[i]) begin
                deb_cnt_reg[i] <= '0;
            end else if (deb_cnt_reg[i] == HVS_DEB_W'(HVS_DEB_CYC - 1)) begin
                deb_reg[i] <= raw_lvl[i]; // RULE_23
                deb_cnt_reg[i] <= '0;
            end else begin
                deb_cnt_reg[i] <= deb_cnt_reg[i] + 1'b1;
            end
        end
    end
    logic panic_db, on_db, off_db, loop_open_db, aux_db;
    assign panic_db = deb_reg[2];
    assign on_db = deb_reg[1];
    assign off_db = deb_reg[0];
    assign loop_open_db = deb_reg[3];
    assign aux_db = deb_reg[4];

    // Press edges of buttons
    logic [2:0] btn_prev_reg;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            btn_prev_reg <= '0;
        end else begin
            btn_prev_reg <= {panic_db, on_db, off_db};
        end
    end
    logic panic_press, on_press, off_press;
    assign panic_press = panic_db & ~btn_prev_reg[2];
    assign on_press = on_db & ~btn_prev_reg[1];
    assign off_press = off_db & ~btn_prev_reg[0];

    hvs_key_t key_pos;
    assign key_pos = hvs_key_t'(key_s2_reg);

    // Avalon slave: one wait cycle, then answer
    logic [7:0] ctrl_reg;
    logic [1:0] if_reg;
    logic cmd_on_pls, cmd_off_pls;
    logic av_ack_reg;
    logic av_req;
    assign av_req = av_req_i.read | av_req_i.write;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            av_ack_reg <= 1'b0;
            av_waitrequest_o <= 1'b1;
        end else begin
            av_ack_reg <= av_req & ~av_ack_reg;
            av_waitrequest_o <= ~(av_req & ~av_ack_reg); // Registered copy of the inverse acknowledge
        end
    end
    logic av_wr;
    assign av_wr = av_req_i.write & av_ack_reg;

    // Control register write
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_reg <= HVS_CTRL_RST;
        end else if (av_wr && av_req_i.address == HVS_CTRL_OFF) begin
            ctrl_reg <= av_req_i.writedata[7:0]; // RULE_13
        end
    end
    // Host commands are single-cycle pulses
    assign cmd_on_pls = av_wr && av_req_i.address == HVS_CMD_OFF && av_req_i.writedata[HVS_CMD_ON_BIT];
    assign cmd_off_pls = av_wr && av_req_i.address == HVS_CMD_OFF && av_req_i.writedata[HVS_CMD_OFF_BIT];

    // Panic latch; set beats clear, and an open loop re-asserts every cycle
    logic panic_reg;
    logic panic_clr;
    assign panic_clr = off_press && key_pos == HVS_KEY_PANEL; // RULE_07
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            panic_reg <= 1'b0;
        end else if (panic_press || loop_open_db) begin
            panic_reg <= 1'b1; // RULE_02 RULE_03 RULE_04
        end else if (panic_clr) begin
            panic_reg <= 1'b0;
        end
    end

    // Module discovery: walk the slots, querying each present module below the slot limit
    logic [3:0] slot_reg;
    logic [15:0] known_reg;
    logic [4:0] slot_lim;
    assign slot_lim = ctrl_reg[HVS_CTRL_LARGE_BIT] ? HVS_SLOTS_LARGE : HVS_SLOTS_SMALL; // RULE_18
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            slot_reg <= '0;
            known_reg <= '0;
            mod_query_o <= '0;
        end else begin
            mod_query_o <= '0;
            if ({1'b0, slot_reg} < slot_lim && mod_present_i[slot_reg]) begin
                mod_query_o[slot_reg] <= ~known_reg[slot_reg]; // RULE_17
                known_reg[slot_reg] <= 1'b1;
            end else begin
                known_reg[slot_reg] <= 1'b0;
            end
            slot_reg <= slot_reg + 4'h1;
        end
    end

    // Ready once standby is left and firmware sets the ready bit
    logic ready;
    assign ready = ctrl_reg[HVS_CTRL_READY_BIT] && key_pos != HVS_KEY_STANDBY;

    // HV generation state; off wins, aux low turns off when enabled
    logic hv_on_reg;
    logic restore_done_reg;
    logic on_req, off_req;
    assign on_req = on_press | cmd_on_pls | (ready & ctrl_reg[HVS_CTRL_RESTORE_BIT] & ~restore_done_reg);
    assign off_req = off_press | cmd_off_pls | (ctrl_reg[HVS_CTRL_AUX_OFF_BIT] & ~aux_db);
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            hv_on_reg <= 1'b0; // RULE_11
            restore_done_reg <= 1'b0;
        end else begin
            if (ready) begin
                restore_done_reg <= 1'b1;
            end
            if (off_req || panic_reg || key_pos == HVS_KEY_STANDBY) begin
                hv_on_reg <= 1'b0; // RULE_08 RULE_15 RULE_06
            end else if (on_req) begin
                hv_on_reg <= 1'b1;
            end
        end
    end

    // Outputs, all registered
    logic any_trip;
    assign any_trip = |(mod_trip_i & known_reg);
    logic st_clamp;
    assign st_clamp = ~ready
        | (ctrl_reg[HVS_CTRL_ST_PANIC_BIT] & panic_reg)
        | (ctrl_reg[HVS_CTRL_ST_TRIP_BIT] & any_trip)
        | (ctrl_reg[HVS_CTRL_ST_OFF_BIT] & ~hv_on_reg); // RULE_12 RULE_14
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mod_power_o <= 1'b0;
            hv_enable_o <= 1'b0;
            internal_power_o <= 1'b0;
            panic_led_o <= 1'b0;
            status_oe_o <= 1'b1;
            status_o <= 1'b0;
            alt_setup_o <= 1'b0;
            host_edit_ok_o <= 1'b0;
            panel_edit_ok_o <= 1'b0;
            mod_ctrl_ok_o <= '0;
            av_readdata_o <= '0;
        end else begin
            internal_power_o <= key_pos != HVS_KEY_STANDBY; // RULE_09
            mod_power_o <= ~panic_reg && key_pos != HVS_KEY_STANDBY; // RULE_01
            hv_enable_o <= hv_on_reg; // RULE_19
            panic_led_o <= panic_reg; // RULE_05
            status_oe_o <= st_clamp; // Open drain: float when not clamped
            status_o <= 1'b0;
            alt_setup_o <= ctrl_reg[HVS_CTRL_AUX_ALT_BIT] & aux_db; // RULE_16
            host_edit_ok_o <= key_pos == HVS_KEY_HOST; // RULE_10
            panel_edit_ok_o <= key_pos == HVS_KEY_PANEL;
            mod_ctrl_ok_o <= known_reg & {16{ready}};
            av_readdata_o <= '0;
            if (av_req_i.read && !av_ack_reg) begin
                case (av_req_i.address)
                    HVS_CTRL_OFF: av_readdata_o <= {24'h0, ctrl_reg};
                    HVS_STAT_OFF: av_readdata_o <= {node_s2_reg, 16'h0, key_s2_reg, aux_db,
                        loop_open_db, any_trip, ready, hv_on_reg, panic_reg}; // RULE_22
                    HVS_MOD_OFF: av_readdata_o <= {16'h0, known_reg};
                    HVS_IF_OFF: av_readdata_o <= {30'h0, if_reg};
                    default: av_readdata_o <= '0;
                endcase
            end
        end
    end

    // Firmware ready flags for prompt and continuation field
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            if_reg <= '0;
        end else if (av_wr && av_req_i.address == HVS_IF_OFF) begin
            if_reg <= av_req_i.writedata[1:0]; // RULE_20 RULE_21
        end
    end

    // Assertions
    property p_panic_led;
        @(posedge ref_clk_i) disable iff (rst_i) panic_reg |=> panic_led_o;
    endproperty
    a_panic_led: assert property (p_panic_led) else $error("led not lit in panic"); // RULE_05
    property p_mod_power;
        @(posedge ref_clk_i) disable iff (rst_i) panic_reg |=> !mod_power_o;
    endproperty
    a_mod_power: assert property (p_mod_power) else $error("module power during panic"); // RULE_01
    property p_loop;
        @(posedge ref_clk_i) disable iff (rst_i) loop_open_db |=> panic_reg;
    endproperty
    a_loop: assert property (p_loop) else $error("open loop did not hold panic"); // RULE_04
    property p_no_on;
        @(posedge ref_clk_i) disable iff (rst_i) panic_reg |=> !hv_on_reg;
    endproperty
    a_no_on: assert property (p_no_on) else $error("hv on during panic"); // RULE_06
    property p_clear;
        @(posedge ref_clk_i) disable iff (rst_i) $fell(panic_reg) |-> $past(panic_clr);
    endproperty
    a_clear: assert property (p_clear) else $error("panic cleared wrongly"); // RULE_07
    property p_off;
        @(posedge ref_clk_i) disable iff (rst_i) cmd_off_pls |=> !hv_on_reg;
    endproperty
    a_off: assert property (p_off) else $error("off refused"); // RULE_08
    property p_standby;
        @(posedge ref_clk_i) disable iff (rst_i) key_pos == HVS_KEY_STANDBY |=> !internal_power_o;
    endproperty
    a_standby: assert property (p_standby) else $error("power in standby"); // RULE_09
    property p_status;
        @(posedge ref_clk_i) disable iff (rst_i) !ready |=> status_oe_o && !status_o;
    endproperty
    a_status: assert property (p_status) else $error("status not clamped"); // RULE_12

    // Panic latch: set, hold and clear steps
    sequence s_loop_open;
        loop_open_db;
    endsequence
    sequence s_shutdown;
        panic_reg ##1 (panic_led_o && !mod_power_o);
    endsequence
    sequence s_clear_req;
        panic_reg && panic_clr && !panic_press && !loop_open_db;
    endsequence
    sequence s_dark;
        !panic_reg ##1 !panic_led_o;
    endsequence
    property p_panic_btn;
        @(posedge ref_clk_i) disable iff (rst_i) panic_press |=> panic_reg;
    endproperty
    a_panic_btn: assert property (p_panic_btn) else $error("panic press not latched"); // RULE_02
    property p_loop_shut;
        @(posedge ref_clk_i) disable iff (rst_i) s_loop_open |=> s_shutdown;
    endproperty
    a_loop_shut: assert property (p_loop_shut) else $error("open loop did not shut down"); // RULE_03
    property p_hold;
        @(posedge ref_clk_i) disable iff (rst_i) panic_reg && !panic_clr |=> panic_reg;
    endproperty
    a_hold: assert property (p_hold) else $error("panic dropped without clear"); // RULE_07
    property p_clear_dark;
        @(posedge ref_clk_i) disable iff (rst_i) s_clear_req |=> s_dark;
    endproperty
    a_clear_dark: assert property (p_clear_dark) else $error("panic clear not carried out"); // RULE_07
    property p_led_dark;
        @(posedge ref_clk_i) disable iff (rst_i) !panic_reg |=> !panic_led_o;
    endproperty
    a_led_dark: assert property (p_led_dark) else $error("led lit without panic"); // RULE_05
    property p_mod_power_ok;
        @(posedge ref_clk_i) disable iff (rst_i) !panic_reg && key_pos != HVS_KEY_STANDBY |=> mod_power_o;
    endproperty
    a_mod_power_ok: assert property (p_mod_power_ok) else $error("module power missing"); // RULE_01

    // Power, enable and edit source checks
    property p_hv_out_panic;
        @(posedge ref_clk_i) disable iff (rst_i) panic_reg |-> ##2 !hv_enable_o;
    endproperty
    a_hv_out_panic: assert property (p_hv_out_panic) else $error("hv enable out during panic"); // RULE_06
    property p_off_btn;
        @(posedge ref_clk_i) disable iff (rst_i) off_press |=> !hv_on_reg;
    endproperty
    a_off_btn: assert property (p_off_btn) else $error("panel off refused"); // RULE_08
    property p_standby_hv;
        @(posedge ref_clk_i) disable iff (rst_i) key_pos == HVS_KEY_STANDBY |=> !hv_on_reg && !mod_power_o;
    endproperty
    a_standby_hv: assert property (p_standby_hv) else $error("hv possible in standby"); // RULE_09
    property p_int_power;
        @(posedge ref_clk_i) disable iff (rst_i) key_pos != HVS_KEY_STANDBY |=> internal_power_o;
    endproperty
    a_int_power: assert property (p_int_power) else $error("internal power missing"); // RULE_09
    property p_host_edit;
        @(posedge ref_clk_i) disable iff (rst_i) key_pos == HVS_KEY_HOST |=> host_edit_ok_o && !panel_edit_ok_o;
    endproperty
    a_host_edit: assert property (p_host_edit) else $error("host edits not selected"); // RULE_10
    property p_panel_edit;
        @(posedge ref_clk_i) disable iff (rst_i) key_pos == HVS_KEY_PANEL |=> panel_edit_ok_o && !host_edit_ok_o;
    endproperty
    a_panel_edit: assert property (p_panel_edit) else $error("panel edits not selected"); // RULE_10
    property p_restore_off;
        @(posedge ref_clk_i) disable iff (rst_i) !ctrl_reg[HVS_CTRL_RESTORE_BIT] && !on_press
            && !cmd_on_pls && !hv_on_reg |=> !hv_on_reg;
    endproperty
    a_restore_off: assert property (p_restore_off) else $error("hv came on unasked"); // RULE_11

    // Status pin, aux input and module checks
    property p_status_follow;
        @(posedge ref_clk_i) disable iff (rst_i) ready && !ctrl_reg[HVS_CTRL_ST_PANIC_BIT]
            && !ctrl_reg[HVS_CTRL_ST_TRIP_BIT] && !ctrl_reg[HVS_CTRL_ST_OFF_BIT] |=> !status_oe_o;
    endproperty
    a_status_follow: assert property (p_status_follow) else $error("status clamped with no cause"); // RULE_13
    property p_status_panic;
        @(posedge ref_clk_i) disable iff (rst_i) ctrl_reg[HVS_CTRL_ST_PANIC_BIT] && panic_reg |=> status_oe_o;
    endproperty
    a_status_panic: assert property (p_status_panic) else $error("status not clamped in panic"); // RULE_14
    property p_aux_off;
        @(posedge ref_clk_i) disable iff (rst_i) ctrl_reg[HVS_CTRL_AUX_OFF_BIT] && !aux_db |=> !hv_on_reg;
    endproperty
    a_aux_off: assert property (p_aux_off) else $error("aux low left hv on"); // RULE_15
    property p_alt_on;
        @(posedge ref_clk_i) disable iff (rst_i) ctrl_reg[HVS_CTRL_AUX_ALT_BIT] && aux_db |=> alt_setup_o;
    endproperty
    a_alt_on: assert property (p_alt_on) else $error("alternate setup not selected"); // RULE_16
    property p_alt_off;
        @(posedge ref_clk_i) disable iff (rst_i) !aux_db |=> !alt_setup_o;
    endproperty
    a_alt_off: assert property (p_alt_off) else $error("alternate setup with aux low"); // RULE_16
    property p_query_lim;
        @(posedge ref_clk_i) disable iff (rst_i) !ctrl_reg[HVS_CTRL_LARGE_BIT] |=> mod_query_o[15:4] == 12'h000;
    endproperty
    a_query_lim: assert property (p_query_lim) else $error("query beyond small chassis"); // RULE_18

    // Bus handshake: one wait cycle, and the answer stands for one cycle only
    property p_av_answer;
        @(posedge ref_clk_i) disable iff (rst_i) $rose(av_req) |=> !av_waitrequest_o;
    endproperty
    a_av_answer: assert property (p_av_answer) else $error("bus answer late");
    property p_av_once;
        @(posedge ref_clk_i) disable iff (rst_i) !av_waitrequest_o |=> av_waitrequest_o;
    endproperty
    a_av_once: assert property (p_av_once) else $error("bus answer held too long");
endmodule

/* File: hvs_mod_model.sv */
module hvs_mod_model #(
    parameter logic [15:0] PRESENT = 16'h0005
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Controller side
    input wire logic [15:0] mod_query_i,
    input wire logic mod_power_i,
    input wire logic trip_req_i,
    // Module side
    output logic [15:0] mod_present_o,
    output logic [15:0] mod_trip_o,
    output logic [15:0] queried_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Installed cards never change while the chassis runs
    assign mod_present_o = PRESENT;
    // An unpowered card cannot report a trip, so power loss clears it
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !mod_power_i) begin
            mod_trip_o <= 16'h0000;
        end else begin
            mod_trip_o <= trip_req_i ? PRESENT : 16'h0000;
        end
    end
    // Remember every query so the bench can see each card was asked
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            queried_o <= 16'h0000;
        end else begin
            queried_o <= queried_o | mod_query_i;
        end
    end
endmodule

/* File: testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import hvs_pkg::*;
    // Slot 5 is only reachable when the large chassis limit is chosen
    localparam logic [15:0] PRES = 16'h0025;
    // Stimulus
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    hvs_av_req_t av_req = '0;
    hvs_panel_t panel = '0;
    logic [1:0] key_pos = 2'h1;
    logic loop_open = 1'b0;
    logic aux = 1'b1;
    logic trip_req = 1'b0;
    logic [31:0] rd;
    int n_mismatch = 0;
    int total_checks = 0;
    // Design outputs
    logic [31:0] rdata;
    logic wreq, mod_pwr, hv_en, alt, int_pwr, led, st_oe, st, host_ok, panel_ok;
    logic [15:0] present, trip, query, ctrl_ok, queried;
    wire status_pin;
    always #2 ref_clk_i = ~ref_clk_i;
    // Open-drain status pin with a pull-up on the far side
    assign status_pin = st_oe ? st : 1'b1;
    hvs_interlock hvs_interlock_i (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .av_req_i(av_req), .av_readdata_o(rdata),
        .av_waitrequest_o(wreq), .panel_i(panel), .key_pos_i(key_pos), .safety_loop_i(loop_open),
        .aux_control_i(aux), .node_addr_sw_i(8'h5a), .mod_present_i(present), .mod_trip_i(trip),
        .mod_query_o(query), .mod_ctrl_ok_o(ctrl_ok), .mod_power_o(mod_pwr), .hv_enable_o(hv_en),
        .alt_setup_o(alt), .internal_power_o(int_pwr), .panic_led_o(led), .status_oe_o(st_oe),
        .status_o(st), .host_edit_ok_o(host_ok), .panel_edit_ok_o(panel_ok));
    hvs_mod_model #(.PRESENT(PRES)) hvs_mod_model_i (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .mod_query_i(query), .mod_power_i(mod_pwr),
        .trip_req_i(trip_req), .mod_present_o(present), .mod_trip_o(trip), .queried_o(queried));
    // Verdict and end of run
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One Avalon transfer; called at a rising edge, returns one edge after release
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        av_req <= '{read: !wr, write: wr, address: a, writedata: d};
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        rd = rdata;
        if (n >= 50) begin
            n_mismatch++;
            $display("ERROR waitrequest expected 0 seen 1");
            conclude();
        end
        av_req <= '0;
        @(posedge ref_clk_i);
    endtask
    // Inputs pass synchronisers and a fixed debounce before acting
    task automatic settle;
        repeat (HVS_DEB_CYC + 20) @(posedge ref_clk_i);
    endtask
    task automatic press(input hvs_panel_t m);
        panel <= m;
        settle();
        panel <= '0;
        settle();
    endtask
    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        chk("status_clamp", 1, st_oe);
        chk("hv_after_reset", 0, hv_en);
        chk("led_idle", 0, led);
        $display("test reset done");
        bus(1, HVS_CTRL_OFF, 32'h0000_0080);
        settle();
        chk("status_ready", 1, status_pin);
        chk("int_power", 1, int_pwr);
        chk("host_edit", 1, host_ok);
        chk("panel_edit", 0, panel_ok);
        chk("hv_default_off", 0, hv_en);
        chk("queried", PRES & 16'h000f, queried);
        chk("ctrl_ok", PRES & 16'h000f, ctrl_ok);
        bus(0, HVS_STAT_OFF, 0);
        chk("node_addr", 8'h5a, rd[31:24]);
        bus(0, 8'h20, 0);
        chk("unmapped", 0, rd);
        bus(1, HVS_IF_OFF, 32'h0000_0003);
        bus(0, HVS_IF_OFF, 0);
        chk("if_flags", 3, rd);
        $display("test ready done");
        bus(1, HVS_CTRL_OFF, 32'h0000_0088);
        settle();
        chk("status_off", 0, status_pin);
        bus(1, HVS_CMD_OFF, 32'h0000_0001);
        settle();
        chk("hv_on", 1, hv_en);
        chk("mod_power", 1, mod_pwr);
        chk("status_on", 1, status_pin);
        bus(1, HVS_CTRL_OFF, 32'h0000_0084);
        trip_req <= 1'b1;
        settle();
        chk("status_trip", 0, status_pin);
        trip_req <= 1'b0;
        $display("test status done");
        bus(1, HVS_CTRL_OFF, 32'h0000_0082);
        press('{panic_btn: 1'b1, on_btn: 1'b0, off_btn: 1'b0});
        chk("panic_led", 1, led);
        chk("panic_power", 0, mod_pwr);
        chk("status_panic", 0, status_pin);
        bus(1, HVS_CMD_OFF, 32'h0000_0001);
        press('{panic_btn: 1'b0, on_btn: 1'b1, off_btn: 1'b0});
        chk("hv_in_panic", 0, hv_en);
        press('{panic_btn: 1'b0, on_btn: 1'b0, off_btn: 1'b1});
        chk("clear_host_key", 1, led);
        key_pos <= 2'h2;
        press('{panic_btn: 1'b0, on_btn: 1'b0, off_btn: 1'b1});
        chk("clear_panel_key", 0, led);
        chk("panel_edit2", 1, panel_ok);
        $display("test panic done");
        loop_open <= 1'b1;
        settle();
        chk("loop_panic", 1, led);
        press('{panic_btn: 1'b0, on_btn: 1'b0, off_btn: 1'b1});
        chk("loop_holds", 1, led);
        loop_open <= 1'b0;
        press('{panic_btn: 1'b0, on_btn: 1'b0, off_btn: 1'b1});
        chk("loop_cleared", 0, led);
        $display("test loop done");
        key_pos <= 2'h1;
        bus(1, HVS_CMD_OFF, 32'h0000_0001);
        settle();
        chk("hv_on2", 1, hv_en);
        key_pos <= 2'h2;
        bus(1, HVS_CMD_OFF, 32'h0000_0002);
        settle();
        chk("remote_off", 0, hv_en);
        key_pos <= 2'h1;
        bus(1, HVS_CTRL_OFF, 32'h0000_00b0);
        bus(1, HVS_CMD_OFF, 32'h0000_0001);
        settle();
        chk("alt_high", 1, alt);
        chk("hv_aux_high", 1, hv_en);
        aux <= 1'b0;
        settle();
        chk("hv_aux_low", 0, hv_en);
        chk("alt_follows", 0, alt);
        aux <= 1'b1;
        $display("test aux done");
        key_pos <= 2'h0;
        settle();
        chk("standby_int", 0, int_pwr);
        chk("standby_mod", 0, mod_pwr);
        chk("standby_hv", 0, hv_en);
        $display("test standby done");
        // Mid-run reset, then auto-restore and the large chassis limit
        key_pos <= 2'h1;
        rst_i <= 1'b1;
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        chk("hv_after_rst2", 0, hv_en);
        chk("status_clamp2", 1, st_oe);
        bus(1, HVS_CTRL_OFF, 32'h0000_00c1);
        settle();
        chk("hv_restored", 1, hv_en);
        chk("queried_large", PRES, queried);
        chk("ctrl_ok_large", PRES, ctrl_ok);
        $display("test restore done");
        conclude();
    end
endmodule
